// File: verilog/aew_cfg.svh
// Offsets, field positions, reset values and limits of the arithmetic error status word block
`ifndef AEW_CFG_SVH
`define AEW_CFG_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define AEW_OFS_STATUS 12'h000
`define AEW_OFS_IRQ_STAT 12'h004
`define AEW_OFS_IRQ_MASK 12'h008
// ----------------------------------------------------------------------
// Field positions of the status word
// ----------------------------------------------------------------------
`define AEW_BIT_BCD 11
`define AEW_BIT_INV 12
`define AEW_BIT_DIVZ 13
`define AEW_BIT_UNF 14
`define AEW_BIT_OVF 15
`define AEW_FLAG_LSB 11
`define AEW_FLAG_MSB 15
// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define AEW_RST_STATUS 16'h0000
`define AEW_RST_FLAGS 5'h00
`define AEW_RST_DATA 32'h0000_0000
`define AEW_BCD_MAX 32'h0000_270F
`define AEW_EXP_MAX 10'sh07F
`define AEW_EXP_MIN 10'sh382
`endif

// File: verilog/aew_pkg.sv
// Types shared by the arithmetic error status word block
package aew_pkg;
   // ----------------------------------------------------------------------
   // Instruction kinds and line endings
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      AEW_OP_NONE, AEW_OP_ADD, AEW_OP_SUB, AEW_OP_MUL, AEW_OP_DIV, AEW_OP_ABS,
      AEW_OP_SQRT, AEW_OP_F2I, AEW_OP_BCD2BIN, AEW_OP_BIN2BCD, AEW_OP_I2F,
      AEW_OP_CMP
   } aew_op_t;
   typedef enum logic {
      AEW_END_COIL, AEW_END_SEND
   } aew_end_t;
endpackage : aew_pkg

// File: verilog/aew_status_word.sv
// Arithmetic error status word, execution gating and APB register file
//
// What this block does
// - Status word is 16 bits; flags in bits 11 to 15, lower byte always zero.
// - Bits 8 to 10 are unused and always read zero.
// - Bit 11 sets on binary above 9999 to BCD, or invalid BCD input.
// - Bit 12 sets on square root of negative or division by zero.
// - Bit 13 sets when a float dividend is divided by zero.
// - Bit 14 sets when a float result is below the minimum normal.
// - Bit 15 sets when a float result magnitude exceeds the maximum.
// - Coil-ended lines execute only with preceding contact on; else coil off.
// - On send-out lines a skip decides whether the operation runs.
// - Contacts at several points combine to decide the value sent out.
// - Each down branch is conditioned anew unless the main line is false.
// - When several branches run, the last executed result replaces earlier ones.
// - Contacts after a math operation do not gate that operation.
// - Word stored only with a destination and listed ops; never for int-to-float.
// - Coil after float math energises on overflow or underflow, else stays off.
`timescale 1ns/10ps
`default_nettype none
`include "aew_cfg.svh"
module aew_status_word (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic step_valid,
   input wire aew_pkg::aew_op_t step_op,
   input wire aew_pkg::aew_end_t step_end,
   input wire logic step_has_dest,
   input wire logic main_ok,
   input wire logic branch_ok,
   input wire logic skip_on,
   input wire logic [31:0] operand_a,
   input wire logic [31:0] operand_b,
   input wire logic signed [9:0] res_exp,
   input wire logic res_zero,
   input wire logic [31:0] step_data,
   output logic [31:0] send_data,
   output logic coil_out,
   output logic [15:0] status_word,
   output logic irq
);
   // ----------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------
   // Float zero test ignores the sign, so minus zero is also a zero divisor
   function automatic logic aew_fzero(input logic [31:0] x);
      aew_fzero = (x[30:0] == 31'h0000_0000);
   endfunction : aew_fzero

   // Any nibble above nine makes the packed BCD pattern invalid
   function automatic logic aew_bcd_bad(input logic [15:0] x);
      logic bad;
      bad = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (x[i*4 +: 4] > 4'h9) begin
            bad = 1'b1;
         end
      end
      aew_bcd_bad = bad;
   endfunction : aew_bcd_bad

   function automatic logic aew_is_float(input aew_pkg::aew_op_t op);
      aew_is_float = (op == aew_pkg::AEW_OP_ADD) || (op == aew_pkg::AEW_OP_SUB) ||
                     (op == aew_pkg::AEW_OP_MUL) || (op == aew_pkg::AEW_OP_DIV) ||
                     (op == aew_pkg::AEW_OP_ABS) || (op == aew_pkg::AEW_OP_SQRT);
   endfunction : aew_is_float

   // ----------------------------------------------------------------------
   // Execution gating
   // ----------------------------------------------------------------------
   logic exec;
   logic store;
   logic listed_op;
   logic is_float;
   // Only contacts ahead of the operation reach this gate; later ones are not inputs
   always_comb begin
      exec = step_valid & main_ok & branch_ok;
      if (step_end == aew_pkg::AEW_END_SEND) begin
         exec = exec & ~skip_on;
      end
   end

   assign is_float = aew_is_float(step_op);
   // Int-to-float and compares never carry a status word
   assign listed_op = is_float || (step_op == aew_pkg::AEW_OP_F2I) ||
                      (step_op == aew_pkg::AEW_OP_BCD2BIN) ||
                      (step_op == aew_pkg::AEW_OP_BIN2BCD);
   assign store = exec & step_has_dest & listed_op;

   // ----------------------------------------------------------------------
   // Flag conditions
   // ----------------------------------------------------------------------
   logic nxt_bcd;
   logic nxt_inv;
   logic nxt_divz;
   logic nxt_unf;
   logic nxt_ovf;
   logic [4:0] nxt_flags;
   logic div_op;
   logic sqrt_neg;

   assign div_op = (step_op == aew_pkg::AEW_OP_DIV) && aew_fzero(operand_b);
   assign sqrt_neg = (step_op == aew_pkg::AEW_OP_SQRT) && operand_a[31] &&
                     !aew_fzero(operand_a);
   // BCD errors from either direction of conversion
   assign nxt_bcd = ((step_op == aew_pkg::AEW_OP_BIN2BCD) && (operand_a > `AEW_BCD_MAX)) ||
                    ((step_op == aew_pkg::AEW_OP_BCD2BIN) && aew_bcd_bad(operand_a[15:0]));
   assign nxt_inv = sqrt_neg || div_op;
   assign nxt_divz = div_op;
   // Exponent is unbiased and unrounded, so range tests are exact against the limits
   assign nxt_unf = is_float && !res_zero && (res_exp < `AEW_EXP_MIN);
   assign nxt_ovf = is_float && (res_exp > `AEW_EXP_MAX);
   assign nxt_flags = {nxt_ovf, nxt_unf, nxt_divz, nxt_inv, nxt_bcd};

   // ----------------------------------------------------------------------
   // Status word store
   // ----------------------------------------------------------------------
   logic [4:0] flags_ff;
   // Whole flag field is rewritten so stale errors never survive a storing instruction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_ff <= `AEW_RST_FLAGS;
      end else if (store) begin
         flags_ff <= nxt_flags;
      end
   end

   // Lower byte and unused bits are tied low at the word
   assign status_word = {flags_ff, 3'h0, 8'h00};

   chk_flag_low: assert property (@(posedge clk) disable iff (!rst_n)
      status_word[10:0] == 11'h000) else $error("unused status bits set");
   chk_flag_rewrite: assert property (@(posedge clk) disable iff (!rst_n)
      store |=> status_word[15:11] == $past(nxt_flags)) else $error("flags not rewritten");
   chk_no_i2f_store: assert property (@(posedge clk) disable iff (!rst_n)
      (step_op == aew_pkg::AEW_OP_I2F || !step_has_dest) |=> $stable(status_word))
      else $error("status stored without destination");
   chk_bcd_range: assert property (@(posedge clk) disable iff (!rst_n)
      (store && step_op == aew_pkg::AEW_OP_BIN2BCD && operand_a > `AEW_BCD_MAX)
      |=> status_word[`AEW_BIT_BCD]) else $error("bcd range flag missing");
   chk_sqrt_neg: assert property (@(posedge clk) disable iff (!rst_n)
      (store && sqrt_neg) |=> status_word[`AEW_BIT_INV] && !status_word[`AEW_BIT_DIVZ])
      else $error("invalid operator flag wrong");
   chk_div_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (store && div_op) |=> status_word[`AEW_BIT_DIVZ] && status_word[`AEW_BIT_INV])
      else $error("divide by zero flags missing");
   chk_underflow_set: assert property (@(posedge clk) disable iff (!rst_n)
      store |=> status_word[`AEW_BIT_UNF] ==
                ($past(is_float) && !$past(res_zero) && ($past(res_exp) < `AEW_EXP_MIN)))
      else $error("underflow flag wrong");
   chk_overflow_set: assert property (@(posedge clk) disable iff (!rst_n)
      store |=> status_word[`AEW_BIT_OVF] ==
                ($past(is_float) && ($past(res_exp) > `AEW_EXP_MAX)))
      else $error("overflow flag wrong");

   // ----------------------------------------------------------------------
   // Sent data and coil
   // ----------------------------------------------------------------------
   logic [31:0] send_ff;
   logic coil_ff;
   // A later branch in the same scan simply loads over an earlier one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         send_ff <= `AEW_RST_DATA;
      end else if (exec && step_end == aew_pkg::AEW_END_SEND) begin
         send_ff <= step_data;
      end
   end

   // Coil reports range trouble after float math, plain result otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coil_ff <= 1'b0;
      end else if (step_valid && step_end == aew_pkg::AEW_END_COIL) begin
         if (!exec) begin
            coil_ff <= 1'b0;
         end else if (is_float) begin
            coil_ff <= nxt_ovf | nxt_unf;
         end else begin
            coil_ff <= step_data[0];
         end
      end
   end

   assign send_data = send_ff;
   assign coil_out = coil_ff;

   chk_coil_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (step_valid && step_end == aew_pkg::AEW_END_COIL && !exec) |=> !coil_out)
      else $error("coil on without contact");
   chk_skip_send: assert property (@(posedge clk) disable iff (!rst_n)
      (step_valid && step_end == aew_pkg::AEW_END_SEND && skip_on) |=>
      $stable(send_data) && $stable(status_word)) else $error("skip ignored");
   chk_main_false: assert property (@(posedge clk) disable iff (!rst_n)
      (step_valid && (!main_ok || !branch_ok)) |=> $stable(send_data))
      else $error("branch ran with false conditioning");
   chk_last_wins: assert property (@(posedge clk) disable iff (!rst_n)
      (exec && step_end == aew_pkg::AEW_END_SEND) |=> send_data == $past(step_data))
      else $error("last branch result lost");
   chk_coil_range: assert property (@(posedge clk) disable iff (!rst_n)
      (exec && step_end == aew_pkg::AEW_END_COIL && is_float) |=>
      coil_out == ($past(nxt_ovf) || $past(nxt_unf))) else $error("range coil wrong");

   // ----------------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------------
   logic [15:0] irq_stat_ff;
   logic [15:0] irq_mask_ff;
   logic irq_ff;
   logic irq_pend;
   logic [15:0] irq_set;
   logic [15:0] irq_clr;
   logic wr_acc;
   // Declared here because the write strobe below already needs it
   logic pready_ff;

   assign wr_acc = psel & penable & pwrite & pready_ff;
   assign irq_pend = |(irq_stat_ff & irq_mask_ff);
   assign irq_set = store ? {nxt_flags, 3'h0, 8'h00} : 16'h0000;
   assign irq_clr = (wr_acc && paddr == `AEW_OFS_IRQ_STAT) ? pwdata[15:0] : 16'h0000;

   // A new event in the clearing cycle wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= `AEW_RST_STATUS;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_ff <= `AEW_RST_STATUS;
      end else if (wr_acc && paddr == `AEW_OFS_IRQ_MASK) begin
         irq_mask_ff <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= irq_pend;
      end
   end

   assign irq = irq_ff;

   chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 irq == $past(irq_pend)) else $error("irq level wrong");

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic mapped;

   assign mapped = (paddr == `AEW_OFS_STATUS) || (paddr == `AEW_OFS_IRQ_STAT) ||
                   (paddr == `AEW_OFS_IRQ_MASK);

   // One wait state: ready rises in the second access cycle, then drops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (psel && penable && !pready_ff) begin
         pready_ff <= 1'b1;
         pslverr_ff <= !mapped;
      end else begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // Read data is captured with ready so it stands during the sampling edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= `AEW_RST_DATA;
      end else if (psel && penable && !pready_ff && !pwrite) begin
         case (paddr)
            `AEW_OFS_STATUS: prdata_ff <= {16'h0000, status_word};
            `AEW_OFS_IRQ_STAT: prdata_ff <= {16'h0000, irq_stat_ff};
            `AEW_OFS_IRQ_MASK: prdata_ff <= {16'h0000, irq_mask_ff};
            default: prdata_ff <= `AEW_RST_DATA;
         endcase
      end else begin
         prdata_ff <= `AEW_RST_DATA;
      end
   end

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

   chk_apb_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (psel && !penable) ##1 (psel && penable) |=> pready) else $error("apb answer late");
endmodule : aew_status_word
`default_nettype wire

// File: sim/test_arith_error_status_word.sv
// Self-checking testbench for the arithmetic error status word block
`timescale 1ns/10ps
`default_nettype none
module test_arith_error_status_word;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, send_data;
   logic pready, pslverr, coil_out, irq;
   logic [15:0] status_word;
   logic step_valid = 1'h0;
   aew_pkg::aew_op_t step_op = aew_pkg::AEW_OP_NONE;
   aew_pkg::aew_end_t step_end = aew_pkg::AEW_END_SEND;
   logic step_has_dest = 1'h0;
   logic main_ok = 1'h0;
   logic branch_ok = 1'h0;
   logic skip_on = 1'h0;
   logic [31:0] operand_a = 32'h0;
   logic [31:0] operand_b = 32'h0;
   logic signed [9:0] res_exp = 10'sh000;
   logic res_zero = 1'h0;
   logic [31:0] step_data = 32'h0;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   integer seed = 32'h51A8F15D;
   logic [15:0] xw = 16'h0;
   logic [15:0] xi = 16'h0;
   logic [31:0] xs = 32'h0;
   logic xc = 1'h0;
   logic lc = 1'h0;
   logic [31:0] rd;
   logic er;
   aew_pkg::aew_op_t ot[10] = '{aew_pkg::AEW_OP_ADD, aew_pkg::AEW_OP_SUB, aew_pkg::AEW_OP_MUL,
      aew_pkg::AEW_OP_DIV, aew_pkg::AEW_OP_BCD2BIN, aew_pkg::AEW_OP_BIN2BCD, aew_pkg::AEW_OP_I2F,
      aew_pkg::AEW_OP_ABS, aew_pkg::AEW_OP_F2I, aew_pkg::AEW_OP_CMP};

   aew_status_word i_aew_status_word (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .step_valid, .step_op, .step_end, .step_has_dest, .main_ok,
      .branch_ok, .skip_on, .operand_a, .operand_b, .res_exp, .res_zero, .step_data, .send_data,
      .coil_out, .status_word, .irq);

   // Clock and hang guard; the ceiling is far above the roughly one thousand cycles used
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict

   task check(input logic [31:0] s, input logic [31:0] e, input string m);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, s, e);
      end
   endtask : check

   // Flags {ovf,unf,divz,inv,bcd} worked out independently of the design
   function automatic logic [4:0] flags(aew_pkg::aew_op_t op, logic [31:0] a, logic [31:0] b,
                                        logic signed [9:0] e, logic z);
      logic fl;
      logic dz;
      fl = op inside {[aew_pkg::AEW_OP_ADD:aew_pkg::AEW_OP_SQRT]};
      dz = op == aew_pkg::AEW_OP_DIV && b[30:0] == 31'h0;
      flags[4] = fl && e > 127;
      flags[3] = fl && !z && e < -126;
      flags[2] = dz;
      flags[1] = dz || (op == aew_pkg::AEW_OP_SQRT && a[31] && a[30:0] != 31'h0);
      flags[0] = (op == aew_pkg::AEW_OP_BIN2BCD && a > 32'h270F) ||
         (op == aew_pkg::AEW_OP_BCD2BIN && (a[3:0] > 9 || a[7:4] > 9 || a[11:8] > 9 || a[15:12] > 9));
   endfunction : flags

   // APB master: holds the request until pready is sampled high
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      // Only the global cycle ceiling ends this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      check(pready, 1, "pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // One instruction step; ctl is {dest, main, branch, skip}; model updated alongside
   task put(input aew_pkg::aew_op_t op, input logic c, input logic [3:0] ctl, input logic [31:0] a,
            input logic [31:0] bb, input logic signed [9:0] e, input logic z, input logic [31:0] d);
      logic [4:0] f;
      logic ex;
      f = flags(op, a, bb, e, z);
      ex = ctl[2] & ctl[1] & (c | !ctl[0]);
      @(posedge clk);
      step_valid <= 1'h1;
      step_op <= op;
      step_end <= c ? aew_pkg::AEW_END_COIL : aew_pkg::AEW_END_SEND;
      step_has_dest <= ctl[3];
      main_ok <= ctl[2];
      branch_ok <= ctl[1];
      skip_on <= ctl[0];
      operand_a <= a;
      operand_b <= bb;
      res_exp <= e;
      res_zero <= z;
      step_data <= d;
      lc = c;
      if (c) xc = ex & (op inside {[aew_pkg::AEW_OP_ADD:aew_pkg::AEW_OP_SQRT]} ? |f[4:3] : d[0]);
      if (ex & !c) xs = d;
      if (ex & ctl[3] & op inside {[aew_pkg::AEW_OP_ADD:aew_pkg::AEW_OP_BIN2BCD]}) begin
         xw = {f, 11'h000};
         xi = xi | xw;
      end
   endtask : put

   task fin();
      @(posedge clk);
      step_valid <= 1'h0;
      #1;
      check(status_word, xw, "status word");
      check(send_data, xs, "send data");
      if (lc) check(coil_out, xc, "coil");
   endtask : fin

   task st(input aew_pkg::aew_op_t op, input logic c, input logic [3:0] ctl, input logic [31:0] a,
           input logic [31:0] bb, input logic signed [9:0] e, input logic z, input logic [31:0] d);
      put(op, c, ctl, a, bb, e, z, d);
      fin();
   endtask : st

   task rput();
      logic [31:0] a;
      a = $random(seed);
      if (a[0]) a = {$random(seed)} % 12000;
      put(ot[{$random(seed)} % 10], 1'($random(seed)), 4'($random(seed)) | 4'h6 & {4{a[1]}}, a,
          ($random(seed) & 3) ? $random(seed) : 32'h0, 10'($random(seed) % 141), 1'h0, $random(seed));
   endtask : rput

   task irq_is(input logic v);
      repeat (2) @(posedge clk);
      #1;
      check(irq, v, "irq level");
   endtask : irq_is

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      check(status_word, 16'h0000, "reset word");
      check(irq, 1'h0, "reset irq");
      st(aew_pkg::AEW_OP_DIV, 1'h0, 4'hE, 32'h3F80_0000, 32'h0, 10'sh000, 1'h0, 32'h1111_1111);
      check(status_word, 16'h3000, "divide by zero word");
      st(aew_pkg::AEW_OP_DIV, 1'h0, 4'hE, 32'h3F80_0000, 32'h8000_0000, 10'sh000, 1'h0, 32'h2);
      st(aew_pkg::AEW_OP_BIN2BCD, 1'h0, 4'hE, 32'h2710, 32'h0, 10'sh000, 1'h0, 32'h3);
      st(aew_pkg::AEW_OP_BIN2BCD, 1'h0, 4'hE, 32'h270F, 32'h0, 10'sh000, 1'h0, 32'h4);
      st(aew_pkg::AEW_OP_BCD2BIN, 1'h0, 4'hE, 32'h00A0, 32'h0, 10'sh000, 1'h0, 32'h5);
      st(aew_pkg::AEW_OP_BCD2BIN, 1'h0, 4'hE, 32'h9999, 32'h0, 10'sh000, 1'h0, 32'h6);
      st(aew_pkg::AEW_OP_SQRT, 1'h0, 4'hE, 32'hC000_0000, 32'h0, 10'sh000, 1'h0, 32'h7);
      st(aew_pkg::AEW_OP_SQRT, 1'h0, 4'hE, 32'h8000_0000, 32'h0, 10'sh000, 1'h0, 32'h8);
      st(aew_pkg::AEW_OP_ADD, 1'h0, 4'hE, 32'h0, 32'h0, 10'sh080, 1'h0, 32'h9);
      st(aew_pkg::AEW_OP_ADD, 1'h0, 4'hE, 32'h0, 32'h0, 10'sh07F, 1'h0, 32'hA);
      st(aew_pkg::AEW_OP_ADD, 1'h0, 4'hE, 32'h0, 32'h0, 10'sh381, 1'h0, 32'hB);
      st(aew_pkg::AEW_OP_I2F, 1'h0, 4'hE, 32'h0, 32'h0, 10'sh080, 1'h0, 32'hC);
      st(aew_pkg::AEW_OP_ADD, 1'h0, 4'h6, 32'h0, 32'h0, 10'sh080, 1'h0, 32'hD);
      st(aew_pkg::AEW_OP_ADD, 1'h0, 4'hE, 32'h0, 32'h0, 10'sh382, 1'h0, 32'hE);
      st(aew_pkg::AEW_OP_ADD, 1'h0, 4'hE, 32'h0, 32'h0, 10'sh381, 1'h1, 32'hF);
      st(aew_pkg::AEW_OP_ADD, 1'h1, 4'hA, 32'h0, 32'h0, 10'sh0C8, 1'h0, 32'h1);
      st(aew_pkg::AEW_OP_ADD, 1'h1, 4'hE, 32'h0, 32'h0, 10'sh0C8, 1'h0, 32'h0);
      st(aew_pkg::AEW_OP_ADD, 1'h1, 4'hE, 32'h0, 32'h0, 10'sh000, 1'h0, 32'h1);
      st(aew_pkg::AEW_OP_BIN2BCD, 1'h1, 4'hF, 32'h1, 32'h0, 10'sh000, 1'h0, 32'h1);
      st(aew_pkg::AEW_OP_DIV, 1'h0, 4'hF, 32'h0, 32'h0, 10'sh000, 1'h0, 32'h77);
      st(aew_pkg::AEW_OP_DIV, 1'h0, 4'hA, 32'h0, 32'h0, 10'sh000, 1'h0, 32'h78);
      st(aew_pkg::AEW_OP_DIV, 1'h0, 4'hC, 32'h0, 32'h0, 10'sh000, 1'h0, 32'h79);
      put(aew_pkg::AEW_OP_ADD, 1'h0, 4'hE, 32'h0, 32'h1, 10'sh000, 1'h0, 32'hAAAA_AAAA);
      st(aew_pkg::AEW_OP_ADD, 1'h0, 4'hE, 32'h0, 32'h1, 10'sh080, 1'h0, 32'h5555_5555);
      // Random steps, sometimes two back to back so the later one must win
      for (int i = 0; i < 300; i++) begin
         rput();
         if ($random(seed) & 1) rput();
         fin();
      end
      // Sticky status, mask, clear and register map
      apb(1'h0, 12'h004, 32'h0);
      check(rd, {16'h0, xi}, "sticky status");
      apb(1'h1, 12'h008, 32'h0000_FFFF);
      apb(1'h0, 12'h008, 32'h0);
      check(rd, 32'h0000_FFFF, "mask readback");
      irq_is(|xi);
      apb(1'h1, 12'h004, {16'h0, xi});
      xi = 16'h0;
      apb(1'h0, 12'h004, 32'h0);
      check(rd, 32'h0, "cleared status");
      irq_is(1'h0);
      st(aew_pkg::AEW_OP_DIV, 1'h0, 4'hE, 32'h1, 32'h0, 10'sh000, 1'h0, 32'h1);
      irq_is(1'h1);
      apb(1'h1, 12'h008, 32'h0);
      irq_is(1'h0);
      apb(1'h1, 12'h000, 32'h0000_FFFF);
      apb(1'h0, 12'h000, 32'h0);
      check(rd, {16'h0, xw}, "read-only word");
      apb(1'h0, 12'h00C, 32'h0);
      check(er, 1'h1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      // Reset in mid-run must clear the status word, send data, irq and the sticky status
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      #1;
      check(status_word, 16'h0000, "mid reset word");
      check(send_data, 32'h0, "mid reset send");
      check(irq, 1'h0, "mid reset irq");
      apb(1'h0, 12'h004, 32'h0);
      check(rd, 32'h0, "mid reset status");
      print_verdict();
   end
endmodule : test_arith_error_status_word
`default_nettype wire
